// ===== shared/sms_pkg.sv
// package: register map, fields, reset values and mode codes for the mode switch block
package sms_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_MODE_MEMORY_SWITCH = 8'h00;
  localparam logic [7:0] ADDR_TORQUE_SWITCH_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_SPEED_SWITCH_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_ACCEL_SWITCH_LEVEL = 8'h0c;
  localparam logic [7:0] ADDR_ERROR_PULSE_SWITCH_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_LOOP_PHASE_COMP_CONSTANT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_INTEG = 8'h1c;
  // mode memory switch bit positions
  localparam int BIT_B = 11;
  localparam int BIT_C = 12;
  localparam int BIT_D = 13;
  // reset values
  localparam logic [15:0] RST_MODE_MEMORY_SWITCH = 16'h0000;
  localparam logic [15:0] RST_TORQUE_LEVEL = 16'h00c8;
  localparam logic [15:0] RST_SPEED_LEVEL = 16'h0000;
  localparam logic [15:0] RST_ACCEL_LEVEL = 16'h0000;
  localparam logic [15:0] RST_ERROR_LEVEL = 16'h2710;
  localparam logic [15:0] RST_PHASE_COMP = 16'h0000;
  // setting limits
  localparam logic [15:0] MAX_ACCEL_LEVEL = 16'h0bb8;
  localparam logic [15:0] MAX_ERROR_LEVEL = 16'h2710;
  localparam logic [15:0] MAX_PHASE_COMP = 16'h0064;
  // detection source codes (bits D,C)
  typedef enum logic [1:0] {
    SMS_SRC_TORQUE = 2'b00,
    SMS_SRC_SPEED = 2'b01,
    SMS_SRC_ACCEL = 2'b10,
    SMS_SRC_ERROR = 2'b11
  } sms_src_t;
  // loop control mode
  typedef enum logic [0:0] {
    SMS_LOOP_PI = 1'b0,
    SMS_LOOP_P = 1'b1
  } sms_loop_t;
endpackage : sms_pkg

// ===== rtl/sms_detect.sv
// detection source select and threshold compare
`timescale 1ns/1ps
`default_nettype none
module sms_detect (
  // configuration
  input wire logic pos_variant,
  input wire logic [15:0] mode_sw,
  input wire logic [15:0] torque_lvl,
  input wire logic [15:0] speed_lvl,
  input wire logic [15:0] accel_lvl,
  input wire logic [15:0] error_lvl,
  // magnitudes of the live quantities
  input wire logic [15:0] torque_mag,
  input wire logic [15:0] speed_mag,
  input wire logic [15:0] accel_mag,
  input wire logic [15:0] error_mag,
  // result
  output logic switch_on
);
  sms_pkg::sms_src_t src;
  logic enabled;

  always_comb begin
    src = sms_pkg::sms_src_t'({mode_sw[sms_pkg::BIT_D], mode_sw[sms_pkg::BIT_C]});
    if (pos_variant) begin
      enabled = ~mode_sw[sms_pkg::BIT_B];
    end else begin
      enabled = (src != sms_pkg::SMS_SRC_ERROR);
    end
    // strictly greater: equal to threshold stays in integral mode
    unique case (src)
      sms_pkg::SMS_SRC_TORQUE: switch_on = enabled & (torque_mag > torque_lvl);
      sms_pkg::SMS_SRC_SPEED: switch_on = enabled & (speed_mag > speed_lvl);
      sms_pkg::SMS_SRC_ACCEL: switch_on = enabled & (accel_mag > accel_lvl);
      sms_pkg::SMS_SRC_ERROR: switch_on = enabled & pos_variant & (error_mag > error_lvl);
    endcase
  end
endmodule : sms_detect
`default_nettype wire

// ===== rtl/sms_comp.sv
// phase delay compensation: gain proportional to the compensation constant
`timescale 1ns/1ps
`default_nettype none
module sms_comp (
  // inputs
  input wire logic pos_variant,
  input wire logic [15:0] comp_const,
  input wire logic signed [15:0] speed_delta,
  // output
  output logic signed [31:0] comp_term
);
  logic signed [16:0] k;

  always_comb begin
    k = $signed({1'b0, comp_const});
    // position variant has no compensation; zero constant gives none
    if (pos_variant) begin
      comp_term = 32'sh0000_0000;
    end else begin
      comp_term = 32'(k * speed_delta);
    end
  end
endmodule : sms_comp
`default_nettype wire

// ===== rtl/sms_mode_switch.sv
// speed loop mode switch with ahb-lite register slave and integrator hold
// Operation
// - position variant: bit B set disables mode switch, clear enables it
// - bits D,C pick torque, speed, acceleration or error pulse source
// - speed/torque variant: bits C and D alone select source and enable
// - condition met forces proportional-only speed loop, else proportional-integral
// - condition is source magnitude strictly above its level constant
// - torque level in percent rated torque, default 200
// - speed level in r/min, default 0
// - acceleration level in 10 (r/min)/s, range 0 to 3000, default 0
// - error pulse level in reference units, range 0 to 10000, default 10000
// - speed/torque variant uses error level as zero-clamp speed level
// - speed/torque variant: compensation gain proportional to constant 0 to 100; 0 means none
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sms_mode_switch (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // variant strap: 1 = position control variant
  input wire logic pos_variant,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // speed loop quantities
  input wire logic sample_valid,
  input wire logic signed [15:0] torque_ref,
  input wire logic signed [15:0] speed_ref,
  input wire logic signed [15:0] accel_ref,
  input wire logic signed [15:0] error_pulse,
  input wire logic signed [15:0] speed_fb,
  // speed loop results
  output logic p_only,
  output logic signed [31:0] integ_out,
  output logic signed [31:0] comp_out,
  output logic zero_clamp_active
);
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag16

  function automatic logic [15:0] clip16(input logic [15:0] v, input logic [15:0] lim);
    clip16 = (v > lim) ? lim : v;
  endfunction : clip16

  // register file
  logic [15:0] mode_sw_ff, nxt_mode_sw;
  logic [15:0] torque_lvl_ff, nxt_torque_lvl;
  logic [15:0] speed_lvl_ff, nxt_speed_lvl;
  logic [15:0] accel_lvl_ff, nxt_accel_lvl;
  logic [15:0] error_lvl_ff, nxt_error_lvl;
  logic [15:0] comp_ff, nxt_comp;
  // bus data phase
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hreadyout_ff, nxt_hreadyout;
  logic hresp_ff, nxt_hresp;
  // loop state
  sms_pkg::sms_loop_t loop_ff, nxt_loop;
  logic signed [31:0] integ_ff, nxt_integ;
  logic signed [31:0] integ_out_ff, nxt_integ_out;
  logic signed [31:0] comp_out_ff, nxt_comp_out;
  logic zclamp_ff, nxt_zclamp;
  logic signed [15:0] speed_prev_ff, nxt_speed_prev;

  logic switch_on;
  logic signed [31:0] comp_term;
  logic signed [16:0] speed_err;
  logic signed [15:0] speed_delta;
  logic addr_ok;
  logic [7:0] a8;

  sms_detect u_detect (
    .pos_variant(pos_variant),
    .mode_sw(mode_sw_ff),
    .torque_lvl(torque_lvl_ff),
    .speed_lvl(speed_lvl_ff),
    .accel_lvl(accel_lvl_ff),
    .error_lvl(error_lvl_ff),
    .torque_mag(mag16(torque_ref)),
    .speed_mag(mag16(speed_ref)),
    .accel_mag(mag16(accel_ref)),
    .error_mag(mag16(error_pulse)),
    .switch_on(switch_on)
  );

  sms_comp u_comp (
    .pos_variant(pos_variant),
    .comp_const(comp_ff),
    .speed_delta(speed_delta),
    .comp_term(comp_term)
  );

  assign a8 = haddr[7:0];
  assign addr_ok = hsel & hready & htrans[1];
  // one bit wider so a full-scale reference against opposite feedback cannot wrap
  assign speed_err = 17'(speed_ref - speed_fb);
  assign speed_delta = 16'(speed_fb - speed_prev_ff);

  // register file: a write lands at the end of its data phase
  always_comb begin
    nxt_mode_sw = mode_sw_ff;
    nxt_torque_lvl = torque_lvl_ff;
    nxt_speed_lvl = speed_lvl_ff;
    nxt_accel_lvl = accel_lvl_ff;
    nxt_error_lvl = error_lvl_ff;
    nxt_comp = comp_ff;
    if (wr_pend_ff) begin
      unique case (wr_addr_ff)
        sms_pkg::ADDR_MODE_MEMORY_SWITCH: nxt_mode_sw = hwdata[15:0];
        sms_pkg::ADDR_TORQUE_SWITCH_LEVEL: nxt_torque_lvl = hwdata[15:0];
        sms_pkg::ADDR_SPEED_SWITCH_LEVEL: nxt_speed_lvl = hwdata[15:0];
        sms_pkg::ADDR_ACCEL_SWITCH_LEVEL: begin
          nxt_accel_lvl = clip16(hwdata[15:0], sms_pkg::MAX_ACCEL_LEVEL);
        end
        sms_pkg::ADDR_ERROR_PULSE_SWITCH_LEVEL: begin
          nxt_error_lvl = clip16(hwdata[15:0], sms_pkg::MAX_ERROR_LEVEL);
        end
        sms_pkg::ADDR_LOOP_PHASE_COMP_CONSTANT: begin
          nxt_comp = clip16(hwdata[15:0], sms_pkg::MAX_PHASE_COMP);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_sw_ff <= sms_pkg::RST_MODE_MEMORY_SWITCH;
      torque_lvl_ff <= sms_pkg::RST_TORQUE_LEVEL;
      speed_lvl_ff <= sms_pkg::RST_SPEED_LEVEL;
      accel_lvl_ff <= sms_pkg::RST_ACCEL_LEVEL;
      error_lvl_ff <= sms_pkg::RST_ERROR_LEVEL;
      comp_ff <= sms_pkg::RST_PHASE_COMP;
    end else if (clk_en) begin
      mode_sw_ff <= nxt_mode_sw;
      torque_lvl_ff <= nxt_torque_lvl;
      speed_lvl_ff <= nxt_speed_lvl;
      accel_lvl_ff <= nxt_accel_lvl;
      error_lvl_ff <= nxt_error_lvl;
      comp_ff <= nxt_comp;
    end
  end

  // bus data phase: zero wait states, read data registered into the data phase
  // hready stays high while clk_en is low, so a transfer offered then is lost
  always_comb begin
    nxt_wr_pend = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_hrdata = hrdata_ff;
    nxt_hreadyout = 1'b1;
    nxt_hresp = 1'b0;
    if (addr_ok) begin
      nxt_wr_pend = hwrite;
      nxt_wr_addr = a8;
      // read data ready for the next cycle; unmapped reads return zero
      if (!hwrite) begin
        unique case (a8)
          sms_pkg::ADDR_MODE_MEMORY_SWITCH: nxt_hrdata = {16'h0000, mode_sw_ff};
          sms_pkg::ADDR_TORQUE_SWITCH_LEVEL: nxt_hrdata = {16'h0000, torque_lvl_ff};
          sms_pkg::ADDR_SPEED_SWITCH_LEVEL: nxt_hrdata = {16'h0000, speed_lvl_ff};
          sms_pkg::ADDR_ACCEL_SWITCH_LEVEL: nxt_hrdata = {16'h0000, accel_lvl_ff};
          sms_pkg::ADDR_ERROR_PULSE_SWITCH_LEVEL: nxt_hrdata = {16'h0000, error_lvl_ff};
          sms_pkg::ADDR_LOOP_PHASE_COMP_CONSTANT: nxt_hrdata = {16'h0000, comp_ff};
          sms_pkg::ADDR_STATUS: nxt_hrdata = {30'h0000_0000, zclamp_ff, loop_ff};
          sms_pkg::ADDR_INTEG: nxt_hrdata = integ_ff;
          default: nxt_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else if (clk_en) begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= nxt_hreadyout;
      hresp_ff <= nxt_hresp;
    end
  end

  // speed loop: mode, integrator, compensation, zero clamp
  always_comb begin
    nxt_loop = loop_ff;
    nxt_integ = integ_ff;
    nxt_integ_out = integ_out_ff;
    nxt_comp_out = comp_out_ff;
    nxt_zclamp = zclamp_ff;
    nxt_speed_prev = speed_prev_ff;
    if (sample_valid) begin
      nxt_loop = switch_on ? sms_pkg::SMS_LOOP_P : sms_pkg::SMS_LOOP_PI;
      // integrator frozen in proportional-only mode, resumes from held value
      if (!switch_on) begin
        nxt_integ = 32'(integ_ff + 32'(speed_err));
      end
      // the integral term is withheld, not lost: integ_ff keeps it for the return to pi
      nxt_integ_out = switch_on ? 32'sh0000_0000 : nxt_integ;
      nxt_comp_out = comp_term;
      nxt_speed_prev = speed_fb;
      // in the speed/torque variant the error level is the zero-clamp speed
      nxt_zclamp = ~pos_variant & (mag16(speed_ref) <= error_lvl_ff);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      loop_ff <= sms_pkg::SMS_LOOP_PI;
      integ_ff <= 32'sh0000_0000;
      integ_out_ff <= 32'sh0000_0000;
      comp_out_ff <= 32'sh0000_0000;
      zclamp_ff <= 1'b0;
      speed_prev_ff <= 16'sh0000;
    end else if (clk_en) begin
      loop_ff <= nxt_loop;
      integ_ff <= nxt_integ;
      integ_out_ff <= nxt_integ_out;
      comp_out_ff <= nxt_comp_out;
      zclamp_ff <= nxt_zclamp;
      speed_prev_ff <= nxt_speed_prev;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign p_only = loop_ff;
  // integral term contributes nothing while proportional-only is in force
  assign integ_out = integ_out_ff;
  assign comp_out = comp_out_ff;
  assign zero_clamp_active = zclamp_ff;
endmodule : sms_mode_switch
`default_nettype wire

// ===== bench/sms_mode_switch_chk.sv
// checker for the mode switch, integrator, clamp and compensation outputs
`timescale 1ns/1ps
`default_nettype none
module sms_mode_switch_chk (
  // clock, reset, strap
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic pos_variant,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // loop
  input wire logic sample_valid,
  input wire logic signed [15:0] torque_ref,
  input wire logic signed [15:0] speed_ref,
  input wire logic signed [15:0] accel_ref,
  input wire logic signed [15:0] error_pulse,
  input wire logic signed [15:0] speed_fb,
  input wire logic p_only,
  input wire logic signed [31:0] integ_out,
  input wire logic signed [31:0] comp_out,
  input wire logic zero_clamp_active
);
  // shadow registers are not clipped: only in-range writes keep them exact
  logic [15:0] reg_ff [8];
  logic [15:0] mag [4];
  logic [2:0] idx_ff;
  logic [1:0] src;
  logic wr_ff, take, over, zc;
  logic signed [31:0] acc_nxt;
  // own integrator model: the port shows zero while proportional-only is in force
  logic signed [31:0] integ_sh_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  function automatic logic [15:0] absv(input logic signed [15:0] x);
    return x[15] ? 16'(-x) : x;
  endfunction : absv
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_ff <= '{16'h0000, 16'h00c8, 16'h0000, 16'h0000, 16'h2710, 16'h0000, 16'h0000, 16'h0000};
      wr_ff <= 1'b0;
      idx_ff <= 3'h0;
      integ_sh_ff <= 32'sh0000_0000;
    end else if (clk_en) begin
      if (take && !over) integ_sh_ff <= acc_nxt;
      wr_ff <= hsel && hready && htrans[1] && hwrite && haddr[7:5] == 3'h0;
      if (hsel && hready && htrans[1]) idx_ff <= haddr[4:2];
      if (wr_ff) reg_ff[idx_ff] <= hwdata[15:0];
    end
  end
  always_comb begin
    src = reg_ff[0][13:12];
    mag = '{absv(torque_ref), absv(speed_ref), absv(accel_ref), absv(error_pulse)};
    take = sample_valid && clk_en;
    over = (pos_variant ? !reg_ff[0][11] : src != 2'b11) && mag[src] > reg_ff[{1'b0, src} + 3'h1];
    zc = !pos_variant && mag[1] <= reg_ff[4];
    acc_nxt = integ_sh_ff + speed_ref - speed_fb;
  end
  b_disable_a: assert property (take && pos_variant && reg_ff[0][11] |=> !p_only)
    else $error("mode switch active with bit b set");
  src_compare_a: assert property (take |=> p_only == $past(over))
    else $error("loop mode differs from selected comparison");
  dc_disable_a: assert property (take && !pos_variant && src == 2'b11 |=> !p_only)
    else $error("mode switch active with d c both set");
  mode_hold_a: assert property (!take |=> $stable(p_only))
    else $error("loop mode moved without a sample");
  integ_hold_a: assert property (take && over |=> integ_out == 0)
    else $error("integral term present in proportional mode");
  integ_add_a: assert property (take && !over |=> integ_out == $past(acc_nxt))
    else $error("integrator did not add the speed error");
  clamp_level_a: assert property (take |=> zero_clamp_active == $past(zc))
    else $error("zero clamp differs from error level compare");
  comp_off_a: assert property (take && (pos_variant || reg_ff[5] == 16'h0000) |=> comp_out == 0)
    else $error("compensation present while off");
endmodule : sms_mode_switch_chk
bind sms_mode_switch sms_mode_switch_chk u_sms_mode_switch_chk (
  .ref_clk, .arst_n, .clk_en, .pos_variant, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .sample_valid, .torque_ref, .speed_ref, .accel_ref, .error_pulse, .speed_fb, .p_only,
  .integ_out, .comp_out, .zero_clamp_active
);
`default_nettype wire

// ===== bench/sms_mode_switch_test.sv
// bench: register defaults, source selection, integrator hold, clamp and compensation
`timescale 1ns/1ps
`default_nettype none
module sms_mode_switch_test;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic pos_variant = 1'b1;
  logic hwrite = 1'b0;
  logic sample_valid = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic signed [15:0] trq = 16'h0000, spd = 16'h0000, acc = 16'h0000, err = 16'h0000;
  logic signed [15:0] fb = 16'h0000;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, p_only, zero_clamp_active;
  wire logic signed [31:0] integ_out, comp_out;
  int error_cnt = 0;
  int checks_done = 0;
  logic [15:0] rst_tab [6] = '{16'h0000, 16'h00c8, 16'h0000, 16'h0000, 16'h2710, 16'h0000};
  sms_mode_switch u_sms_mode_switch (
    .ref_clk, .arst_n, .clk_en, .pos_variant, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sample_valid,
    .torque_ref(trq), .speed_ref(spd), .accel_ref(acc), .error_pulse(err), .speed_fb(fb),
    .p_only, .integ_out, .comp_out, .zero_clamp_active
  );
  always #20 ref_clk = ~ref_clk;
  task conclude;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // slave is zero wait, but the wait stays bounded in case hreadyout drops
  task rdy;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        conclude;
      end
      @(posedge ref_clk);
    end
  endtask : rdy
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    rdy;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    rdy;
    q = hrdata;
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : bus
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rc(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(q, {16'h0000, exp});
  endtask : rc
  task rst;
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
  endtask : rst
  // selected source gets v, every other reference gets o, feedback gets f
  task smp(input int s, input logic [15:0] v, input logic [15:0] o, input logic [15:0] f);
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    trq <= (s == 0) ? v : o;
    spd <= (s == 1) ? v : o;
    acc <= (s == 2) ? v : o;
    err <= (s == 3) ? v : o;
    fb <= f;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    #1;
  endtask : smp
  initial begin
    rst;
    for (int i = 0; i < 6; i++) rc(8'(4 * i), rst_tab[i]);
    rc(8'h20, 16'h0000);
    wr(sms_pkg::ADDR_ACCEL_SWITCH_LEVEL, sms_pkg::MAX_ACCEL_LEVEL);
    rc(sms_pkg::ADDR_ACCEL_SWITCH_LEVEL, sms_pkg::MAX_ACCEL_LEVEL);
    wr(sms_pkg::ADDR_LOOP_PHASE_COMP_CONSTANT, 16'h00c8);
    rc(sms_pkg::ADDR_LOOP_PHASE_COMP_CONSTANT, sms_pkg::MAX_PHASE_COMP);
    rst;
    smp(0, 16'h00c8, 16'h012c, 16'h0064);
    chk({31'h0000_0000, p_only}, 32'h0000_0000);
    chk(integ_out, 32'h0000_00c8);
    smp(0, 16'h00c9, 16'h012c, 16'h0064);
    chk({31'h0000_0000, p_only}, 32'h0000_0001);
    chk(integ_out, 32'h0000_0000);
    smp(0, 16'h000a, 16'h012c, 16'h00fa);
    chk(integ_out, 32'h0000_00fa);
    clk_en <= 1'b0;
    smp(0, 16'h00c9, 16'h012c, 16'h0064);
    chk({31'h0000_0000, p_only}, 32'h0000_0000);
    chk(integ_out, 32'h0000_00fa);
    clk_en <= 1'b1;
    for (int i = 1; i < 5; i++) wr(8'(4 * i), 16'h0064);
    for (int s = 0; s < 4; s++) begin
      wr(sms_pkg::ADDR_MODE_MEMORY_SWITCH, 16'(s << 12));
      smp(s, 16'h0064, 16'h01f4, 16'h0000);
      chk({31'h0000_0000, p_only}, 32'h0000_0000);
      smp(s, 16'h0065, 16'h0000, 16'h0000);
      chk({31'h0000_0000, p_only}, 32'h0000_0001);
    end
    wr(sms_pkg::ADDR_MODE_MEMORY_SWITCH, 16'h2800);
    smp(2, 16'h0065, 16'h0000, 16'h0000);
    chk({31'h0000_0000, p_only}, 32'h0000_0000);
    pos_variant <= 1'b0;
    wr(sms_pkg::ADDR_MODE_MEMORY_SWITCH, 16'h3000);
    smp(3, 16'h0065, 16'h0065, 16'h0000);
    chk({31'h0000_0000, p_only}, 32'h0000_0000);
    wr(sms_pkg::ADDR_MODE_MEMORY_SWITCH, 16'h1800);
    smp(0, 16'h0000, 16'h0064, 16'h0000);
    chk({31'h0000_0000, zero_clamp_active}, 32'h0000_0001);
    rc(sms_pkg::ADDR_STATUS, 16'h0002);
    rc(sms_pkg::ADDR_INTEG, 16'h0803);
    smp(1, 16'h0065, 16'h0000, 16'h0000);
    chk({31'h0000_0000, zero_clamp_active}, 32'h0000_0000);
    chk({31'h0000_0000, p_only}, 32'h0000_0001);
    wr(sms_pkg::ADDR_LOOP_PHASE_COMP_CONSTANT, 16'h0005);
    smp(0, 16'h0000, 16'h0000, 16'h000a);
    smp(0, 16'h0000, 16'h0000, 16'h001e);
    chk(comp_out, 32'h0000_0064);
    wr(sms_pkg::ADDR_LOOP_PHASE_COMP_CONSTANT, 16'h0000);
    smp(0, 16'h0000, 16'h0000, 16'h0032);
    chk(comp_out, 32'h0000_0000);
    wr(sms_pkg::ADDR_LOOP_PHASE_COMP_CONSTANT, 16'h0005);
    pos_variant <= 1'b1;
    smp(0, 16'h0000, 16'h0064, 16'h0000);
    chk({31'h0000_0000, zero_clamp_active}, 32'h0000_0000);
    chk(comp_out, 32'h0000_0000);
    conclude;
  end
endmodule : sms_mode_switch_test
`default_nettype wire
